//--- src/pmwp_pkg.sv
package pmwp_pkg;

  // Register indices on the plain register port.
  localparam logic [1:0] PMWP_IDX_MEMPROT = 2'h0;
  localparam logic [1:0] PMWP_IDX_CODEPROT = 2'h1;
  localparam logic [1:0] PMWP_IDX_STATUS = 2'h2;
  localparam logic [1:0] PMWP_IDX_ERASE = 2'h3;

  localparam int PMWP_WORD_W = 14;

  // Memory-protection and code-protection word field positions.
  localparam int PMWP_BIT_CFG_LOCK = 9;
  localparam int PMWP_BIT_BOOT_LOCK = 8;
  localparam int PMWP_BIT_APP_LOCK = 7;
  localparam int PMWP_BIT_STOR_EN_N = 4;
  localparam int PMWP_BIT_BOOT_EN_N = 3;
  localparam int PMWP_BIT_SIZE_LO = 0;
  localparam int PMWP_BIT_STOR_LOCK = 11;
  localparam int PMWP_BIT_CODE_PROT_N = 0;

  // Bits that software may clear in each word; all others are fixed at one.
  localparam logic [13:0] PMWP_MEMPROT_IMPL = 14'h0B9F;
  localparam logic [13:0] PMWP_CODEPROT_IMPL = 14'h0001;
  localparam logic [13:0] PMWP_ERASED = 14'h3FFF;

  // Boot region sizing, in words.
  localparam logic [2:0] PMWP_SIZE_CODE_SMALL = 3'h7;
  localparam logic [15:0] PMWP_BOOT_SMALL_WORDS = 16'h0200;
  localparam logic [15:0] PMWP_BOOT_LARGE_WORDS = 16'h0400;
  localparam logic [15:0] PMWP_PROG_WORDS = 16'h0800;
  localparam logic [15:0] PMWP_STOR_WORDS = 16'h0080;

  localparam logic [13:0] PMWP_ERASE_KEY = 14'h2A55;

endpackage

//--- src/pmwp_boot_size.sv
`timescale 1ns/1ps
`default_nettype none
module pmwp_boot_size
  import pmwp_pkg::*;
#(
  parameter logic [15:0] PROG_WORDS = PMWP_PROG_WORDS
) (
  // Configuration fields
  input wire logic boot_en_n_i,
  input wire logic [2:0] size_code_i,
  // Decoded size in words
  output logic [15:0] boot_words_o
);

  logic [15:0] raw_words;
  logic [15:0] half_words;

  assign half_words = PROG_WORDS >> 1;

  always_comb begin
    if (boot_en_n_i) begin
      raw_words = 16'h0000;
    end else if (size_code_i == PMWP_SIZE_CODE_SMALL) begin
      raw_words = PMWP_BOOT_SMALL_WORDS;
    end else begin
      raw_words = PMWP_BOOT_LARGE_WORDS;
    end
  end

  // Oversized codes fold silently onto the half-memory size.
  assign boot_words_o = (raw_words > half_words) ? half_words : raw_words;

endmodule
`default_nettype wire

//--- src/pmwp_top.sv
// Behaviour
// - Application region self-writes blocked when its lock flag is 0.
// - Boot lock flag matters only while the boot region is enabled.
// - Boot size: disabled 0, code 111 is 512 words, else 1024.
// - Boot region never exceeds half of program memory.
// - Oversized codes give half size, silently.
// - Protection bits only clear on writes; only reset and bulk erase set them.
// - Code protect flag 0 enables protection; erased value is 1.
// - Code protection word bits 13 to 1 read as 1.
// - Memory protection word bits 13, 12, 10, 6, 5 read as 1.
// - Under code protection external accesses refused, reads return zero.
// - Internal fetches and reads are never affected.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pmwp_top
  import pmwp_pkg::*;
#(
  parameter logic [15:0] PROG_WORDS = PMWP_PROG_WORDS,
  parameter logic [15:0] STOR_WORDS = PMWP_STOR_WORDS
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [13:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [13:0] reg_rdata_o,
  // Self-write check
  input wire logic self_wr_i,
  input wire logic [15:0] self_addr_i,
  output logic self_wr_ok_o,
  output logic self_wr_blocked_o,
  // External programming port
  input wire logic ext_rd_i,
  input wire logic ext_wr_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [13:0] ext_mem_data_i,
  output logic [13:0] ext_rdata_o,
  output logic ext_wr_ok_o,
  output logic ext_refused_o,
  // Internal fetch path
  input wire logic cpu_rd_i,
  input wire logic [13:0] cpu_mem_data_i,
  output logic [13:0] cpu_rdata_o,
  // Decoded controls
  output logic [15:0] boot_words_o,
  output logic code_protect_o
);

  logic [13:0] memprot;
  logic [13:0] codeprot;
  logic [15:0] boot_words;
  logic boot_lock_eff;
  logic stor_present;
  logic [15:0] stor_base;
  logic next_self_ok;

  function automatic logic [13:0] sticky_write(input logic [13:0] cur,
      input logic [13:0] wd, input logic [13:0] impl);
    // Only implemented bits can be cleared; nothing can be set back to one.
    sticky_write = cur & (wd | ~impl);
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      memprot <= PMWP_ERASED;
    end else if (en_i) begin
      if (reg_wr_i && reg_addr_i == PMWP_IDX_ERASE && reg_wdata_i == PMWP_ERASE_KEY) begin
        memprot <= PMWP_ERASED;
      end else if (reg_wr_i && reg_addr_i == PMWP_IDX_MEMPROT) begin
        memprot <= sticky_write(memprot, reg_wdata_i, PMWP_MEMPROT_IMPL);
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      codeprot <= PMWP_ERASED;
    end else if (en_i) begin
      if (reg_wr_i && reg_addr_i == PMWP_IDX_ERASE && reg_wdata_i == PMWP_ERASE_KEY) begin
        codeprot <= PMWP_ERASED;
      end else if (reg_wr_i && reg_addr_i == PMWP_IDX_CODEPROT) begin
        codeprot <= sticky_write(codeprot, reg_wdata_i, PMWP_CODEPROT_IMPL);
      end
    end
  end

  pmwp_boot_size #(
    .PROG_WORDS(PROG_WORDS)
  ) u_size (
    .boot_en_n_i(memprot[PMWP_BIT_BOOT_EN_N]),
    .size_code_i(memprot[PMWP_BIT_SIZE_LO +: 3]),
    .boot_words_o(boot_words)
  );

  assign boot_lock_eff = !memprot[PMWP_BIT_BOOT_EN_N] && !memprot[PMWP_BIT_BOOT_LOCK];
  assign stor_present = !memprot[PMWP_BIT_STOR_EN_N];
  assign stor_base = PROG_WORDS - STOR_WORDS;

  // Region check; the storage area only carves out words while enabled.
  always_comb begin
    next_self_ok = 1'b1;
    if (self_addr_i >= PROG_WORDS) begin
      next_self_ok = memprot[PMWP_BIT_CFG_LOCK];
    end else if (self_addr_i < boot_words) begin
      next_self_ok = !boot_lock_eff;
    end else if (stor_present && self_addr_i >= stor_base) begin
      next_self_ok = memprot[PMWP_BIT_STOR_LOCK];
    end else begin
      next_self_ok = memprot[PMWP_BIT_APP_LOCK];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      self_wr_ok_o <= 1'b0;
      self_wr_blocked_o <= 1'b0;
    end else if (en_i) begin
      self_wr_ok_o <= self_wr_i && next_self_ok;
      self_wr_blocked_o <= self_wr_i && !next_self_ok;
    end
  end

  // Refused reads return zeros so no protected word ever leaks.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_rdata_o <= 14'h0000;
      ext_wr_ok_o <= 1'b0;
      ext_refused_o <= 1'b0;
    end else if (en_i) begin
      ext_rdata_o <= (ext_rd_i && codeprot[PMWP_BIT_CODE_PROT_N]) ? ext_mem_data_i
                                                                   : 14'h0000;
      ext_wr_ok_o <= ext_wr_i && codeprot[PMWP_BIT_CODE_PROT_N];
      ext_refused_o <= (ext_rd_i || ext_wr_i) && !codeprot[PMWP_BIT_CODE_PROT_N];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_rdata_o <= 14'h0000;
    end else if (en_i && cpu_rd_i) begin
      cpu_rdata_o <= cpu_mem_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_words_o <= 16'h0000;
      code_protect_o <= 1'b0;
    end else if (en_i) begin
      boot_words_o <= boot_words;
      code_protect_o <= !codeprot[PMWP_BIT_CODE_PROT_N];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 14'h0000;
    end else if (en_i) begin
      if (reg_rd_i) begin
        case (reg_addr_i)
          PMWP_IDX_MEMPROT: reg_rdata_o <= memprot | ~PMWP_MEMPROT_IMPL;
          PMWP_IDX_CODEPROT: reg_rdata_o <= codeprot | ~PMWP_CODEPROT_IMPL;
          PMWP_IDX_STATUS: reg_rdata_o <= {boot_lock_eff, stor_present,
                                           !codeprot[PMWP_BIT_CODE_PROT_N], 11'h000};
          default: reg_rdata_o <= 14'h0000;
        endcase
      end else begin
        reg_rdata_o <= 14'h0000;
      end
    end
  end

  a_sticky_mem: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && !(reg_wr_i && reg_addr_i == PMWP_IDX_ERASE)) |=> ((memprot & ~$past(memprot)) == 14'h0000))
    else $error("protection bit set without erase");
  a_sticky_code: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && !(reg_wr_i && reg_addr_i == PMWP_IDX_ERASE) && !codeprot[0]) |=> !codeprot[0])
    else $error("code protect bit set without erase");
  a_app_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && self_wr_i && self_addr_i < PROG_WORDS && self_addr_i >= PMWP_BOOT_LARGE_WORDS
     && !stor_present && !memprot[PMWP_BIT_APP_LOCK]) |=> (self_wr_blocked_o && !self_wr_ok_o))
    else $error("application write not blocked");
  a_boot_ignored: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && self_wr_i && memprot[PMWP_BIT_BOOT_EN_N] && self_addr_i < PMWP_BOOT_SMALL_WORDS
     && memprot[PMWP_BIT_APP_LOCK]) |=> self_wr_ok_o)
    else $error("boot lock acted while boot disabled");
  // The decoded size is registered, so it follows the word as it stood one edge earlier.
  a_boot_size: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i |=> (boot_words_o == ($past(memprot[3]) ? 16'h0000 :
      ($past(memprot[2:0]) == 3'h7 ? 16'h0200 :
      ((16'h0400 > (PROG_WORDS >> 1)) ? (PROG_WORDS >> 1) : 16'h0400)))))
    else $error("boot size decode wrong");
  a_boot_half: assert property (@(posedge clk_i) disable iff (!nrst_i)
    boot_words <= (PROG_WORDS >> 1))
    else $error("boot region above half memory");
  a_ext_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && ext_rd_i && !codeprot[0]) |=> (ext_rdata_o == 14'h0000 && ext_refused_o))
    else $error("protected external read leaked");
  a_ext_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && ext_wr_i && !codeprot[0]) |=> !ext_wr_ok_o)
    else $error("protected external write allowed");
  a_cpu_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && cpu_rd_i) |=> (cpu_rdata_o == $past(cpu_mem_data_i)))
    else $error("internal read disturbed");
  a_read_ones: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && reg_rd_i && reg_addr_i == PMWP_IDX_CODEPROT) |=> (reg_rdata_o[13:1] == 13'h1FFF))
    else $error("unimplemented bits not one");
  a_code_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i |=> (code_protect_o == !$past(codeprot[0])))
    else $error("code protect polarity wrong");

  // A self-write is a request in one cycle and a verdict pulse in the next.
  sequence s_boot_locked_wr;
    en_i && self_wr_i && self_addr_i < boot_words && boot_lock_eff;
  endsequence

  sequence s_stor_locked_wr;
    en_i && self_wr_i && stor_present && self_addr_i < PROG_WORDS
      && self_addr_i >= stor_base && self_addr_i >= boot_words
      && !memprot[PMWP_BIT_STOR_LOCK];
  endsequence

  sequence s_blocked_answer;
    self_wr_blocked_o && !self_wr_ok_o;
  endsequence

  a_boot_lock_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_boot_locked_wr |=> s_blocked_answer)
    else $error("boot write not blocked");
  a_stor_lock_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_stor_locked_wr |=> s_blocked_answer)
    else $error("storage write not blocked");
  a_memprot_ones: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && reg_rd_i && reg_addr_i == PMWP_IDX_MEMPROT)
      |=> ((reg_rdata_o & ~PMWP_MEMPROT_IMPL) == ~PMWP_MEMPROT_IMPL))
    else $error("unimplemented protection bits not one");
  a_erase_all: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && reg_wr_i && reg_addr_i == PMWP_IDX_ERASE && reg_wdata_i == PMWP_ERASE_KEY)
      |=> (memprot == PMWP_ERASED && codeprot == PMWP_ERASED))
    else $error("bulk erase did not restore words");
  a_ext_open: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && ext_rd_i && codeprot[PMWP_BIT_CODE_PROT_N])
      |=> (ext_rdata_o == $past(ext_mem_data_i) && !ext_refused_o))
    else $error("unprotected external read refused");
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && !reg_rd_i) |=> (reg_rdata_o == 14'h0000))
    else $error("read data stood beyond its cycle");
  a_freeze_state: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !en_i |=> ($stable(memprot) && $stable(codeprot) && $stable(boot_words_o)))
    else $error("state moved while disabled");

endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmwp_pkg::*;
  // A smaller memory than the default, so that the half-size clamp really bites.
  localparam logic [15:0] PW = 16'h0600;
  localparam logic [15:0] SW = 16'h0080;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic en_i = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [13:0] reg_wdata_i = 14'h0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, self_wr_i = 1'b0;
  logic ext_rd_i = 1'b0, ext_wr_i = 1'b0, cpu_rd_i = 1'b0;
  logic [15:0] self_addr_i = 16'h0000, ext_addr_i = 16'h0000;
  logic [13:0] ext_mem_data_i = 14'h0000, cpu_mem_data_i = 14'h0000;
  logic [13:0] reg_rdata_o, ext_rdata_o, cpu_rdata_o;
  logic self_wr_ok_o, self_wr_blocked_o, ext_wr_ok_o, ext_refused_o, code_protect_o;
  logic [15:0] boot_words_o;
  logic [13:0] mp, cp, wd;
  logic [15:0] pts [6];
  int n_fail = 0, n_checks = 0;

  pmwp_top #(.PROG_WORDS(PW), .STOR_WORDS(SW)) dut (.clk_i, .nrst_i, .en_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .self_wr_i, .self_addr_i, .self_wr_ok_o,
    .self_wr_blocked_o, .ext_rd_i, .ext_wr_i, .ext_addr_i, .ext_mem_data_i, .ext_rdata_o,
    .ext_wr_ok_o, .ext_refused_o, .cpu_rd_i, .cpu_mem_data_i, .cpu_rdata_o, .boot_words_o,
    .code_protect_o);

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] boot_exp();
    logic [15:0] sz;
    sz = (mp[2:0] == 3'h7) ? 16'h0200 : 16'h0400;
    if (mp[3]) return 16'h0000;
    return (sz > (PW >> 1)) ? (PW >> 1) : sz;
  endfunction

  function automatic logic ok_exp(logic [15:0] a);
    if (a >= PW) return mp[9];
    if (a < boot_exp()) return mp[8];
    if (!mp[4] && a >= PW - SW) return mp[11];
    return mp[7];
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic reg_wr(logic [1:0] a, logic [13:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    if (en_i && a == PMWP_IDX_MEMPROT) mp = mp & (d | ~PMWP_MEMPROT_IMPL);
    if (en_i && a == PMWP_IDX_CODEPROT) cp = cp & (d | ~PMWP_CODEPROT_IMPL);
    if (en_i && a == PMWP_IDX_ERASE && d == PMWP_ERASE_KEY) begin
      mp = PMWP_ERASED;
      cp = PMWP_ERASED;
    end
  endtask

  task automatic reg_rd(logic [1:0] a, logic [13:0] exp, logic [13:0] msk);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg_rdata", {2'h0, reg_rdata_o & msk}, {2'h0, exp & msk});
  endtask

  // The decoded outputs are registered, so a few edges are allowed to pass first.
  task automatic settle_chk();
    repeat (3) @(posedge clk_i);
    #1 chk("boot_words", boot_words_o, boot_exp());
    chk("code_protect", 16'(code_protect_o), 16'(!cp[0]));
  endtask

  task automatic self_w(logic [15:0] a);
    @(posedge clk_i);
    self_addr_i <= a;
    self_wr_i <= 1'b1;
    @(posedge clk_i);
    self_wr_i <= 1'b0;
    #1 chk("self_wr_ok", 16'(self_wr_ok_o), 16'(ok_exp(a)));
    chk("self_wr_blocked", 16'(self_wr_blocked_o), 16'(!ok_exp(a)));
  endtask

  task automatic ext_acc(logic rd, logic [13:0] d);
    @(posedge clk_i);
    ext_rd_i <= rd;
    ext_wr_i <= !rd;
    ext_mem_data_i <= d;
    ext_addr_i <= 16'($urandom_range(0, 32'h05FF));
    cpu_rd_i <= 1'b1;
    cpu_mem_data_i <= ~d;
    @(posedge clk_i);
    ext_rd_i <= 1'b0;
    ext_wr_i <= 1'b0;
    cpu_rd_i <= 1'b0;
    #1 chk("ext_rdata", {2'h0, ext_rdata_o}, (rd && cp[0]) ? {2'h0, d} : 16'h0000);
    chk("ext_refused", 16'(ext_refused_o), 16'(!cp[0]));
    chk("ext_wr_ok", 16'(ext_wr_ok_o), 16'(!rd && cp[0]));
    chk("cpu_rdata", {2'h0, cpu_rdata_o}, {2'h0, ~d});
  endtask

  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(79158));
    mp = PMWP_ERASED;
    cp = PMWP_ERASED;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    reg_rd(PMWP_IDX_MEMPROT, 14'h3FFF, 14'h3FFF);
    reg_rd(PMWP_IDX_CODEPROT, 14'h3FFF, 14'h3FFF);
    settle_chk();
    // Codes 0 to 7 with the boot region on, then two runs with it off.
    for (int c = 0; c < 10; c++) begin
      reg_wr(PMWP_IDX_ERASE, PMWP_ERASE_KEY);
      wd = 14'($urandom());
      wd[2:0] = 3'(c);
      wd[3] = (c > 7);
      reg_wr(PMWP_IDX_MEMPROT, wd);
      reg_rd(PMWP_IDX_MEMPROT, mp | ~PMWP_MEMPROT_IMPL, 14'h3FFF);
      settle_chk();
      reg_rd(PMWP_IDX_STATUS, {!mp[3] && !mp[8], !mp[4], !cp[0], 11'h000}, 14'h3800);
      pts = '{16'h0000, boot_exp() - 16'h0001, boot_exp(), PW - SW - 16'h0001, PW - SW, PW};
      for (int k = 0; k < 6; k++) self_w(pts[k]);
      repeat (4) self_w(16'($urandom_range(0, 32'h07FF)));
      reg_wr(PMWP_IDX_MEMPROT, 14'h3FFF);
      reg_rd(PMWP_IDX_MEMPROT, mp | ~PMWP_MEMPROT_IMPL, 14'h3FFF);
    end
    reg_wr(PMWP_IDX_ERASE, PMWP_ERASE_KEY);
    ext_acc(1'b1, 14'($urandom()));
    ext_acc(1'b0, 14'($urandom()));
    reg_wr(PMWP_IDX_CODEPROT, 14'h0000);
    reg_rd(PMWP_IDX_CODEPROT, 14'h3FFE, 14'h3FFF);
    settle_chk();
    ext_acc(1'b1, 14'($urandom()));
    ext_acc(1'b0, 14'($urandom()));
    reg_wr(PMWP_IDX_CODEPROT, 14'h3FFF);
    reg_wr(PMWP_IDX_ERASE, 14'h1234);
    @(posedge clk_i);
    en_i <= 1'b0;
    reg_wr(PMWP_IDX_ERASE, PMWP_ERASE_KEY);
    en_i <= 1'b1;
    reg_rd(PMWP_IDX_CODEPROT, 14'h3FFE, 14'h3FFF);
    reg_wr(PMWP_IDX_ERASE, PMWP_ERASE_KEY);
    reg_rd(PMWP_IDX_CODEPROT, 14'h3FFF, 14'h3FFF);
    settle_chk();
    close_out();
  end
endmodule
`default_nettype wire
